// ==== rtl/vpc_pkg.sv ====
package vpc_pkg;
   // ----------------------------------------
   // bus addressing
   // ----------------------------------------
   localparam logic [7:0] VPC_DEV_WR_ADDR = 8'hDC;
   localparam int VPC_OFS_CONTRAST = 1;
   localparam int VPC_OFS_LUMA_OFFSET = 2;
   localparam int VPC_OFS_GAIN_ONE = 3;
   localparam int VPC_OFS_GAIN_TWO = 4;
   localparam int VPC_OFS_GAIN_THREE = 5;
   localparam int VPC_OFS_LUMA_SPAN = 6;
   localparam int VPC_OFS_OVERLAY = 7;
   localparam int VPC_OFS_CLAMP_CFG = 8;
   localparam int VPC_OFS_AMP_CFG = 9;
   localparam int VPC_OFS_CUTOFF1 = 10;
   localparam int VPC_OFS_CUTOFF2 = 11;
   localparam int VPC_OFS_CUTOFF3 = 12;
   localparam int VPC_OFS_SLEEP_CFG = 13;
   localparam int VPC_OFS_INFRA_CFG = 14;
   localparam int VPC_OFS_ENH_MAIN = 15;
   localparam int VPC_OFS_ENH_SHARP = 16;

   // ----------------------------------------
   // values after power-on
   // ----------------------------------------
   localparam logic [7:0] VPC_RST_VAL [VPC_OFS_CONTRAST:VPC_OFS_ENH_SHARP] = '{
      8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h01, 8'h09, 8'h04,
      8'h10, 8'h80, 8'h80, 8'h80, 8'h08, 8'hC1, 8'h09, 8'h28};

   // ----------------------------------------
   // single-bit field positions
   // ----------------------------------------
   localparam int VPC_B_OUT_CLAMP_SRC = 7;
   localparam int VPC_B_TEST_A = 6;
   localparam int VPC_B_SRC_HI = 4;
   localparam int VPC_B_EDGE = 1;
   localparam int VPC_B_SRC_LO = 0;
   localparam int VPC_B_AMP_SLEEP = 7;
   localparam int VPC_B_AMP_BLANK = 6;
   localparam int VPC_B_COUPLE = 2;
   localparam int VPC_B_SOFT_BLANK = 1;
   localparam int VPC_B_FLY_INV = 0;
   localparam int VPC_B_FULL_SLEEP = 7;
   localparam int VPC_B_INFRA_DEPTH = 7;
   localparam int VPC_B_CUTOFF_SPAN = 0;

   // ----------------------------------------
   // clamp pulse widths
   // ----------------------------------------
   localparam int VPC_CLK_NS = 10;
   localparam int VPC_W0_NS = 330;
   localparam int VPC_W1_NS = 660;
   localparam int VPC_W2_NS = 1000;
   localparam int VPC_W3_NS = 1330;
   localparam int VPC_W0_CYC = (VPC_W0_NS + VPC_CLK_NS - 1) / VPC_CLK_NS;
   localparam int VPC_W1_CYC = (VPC_W1_NS + VPC_CLK_NS - 1) / VPC_CLK_NS;
   localparam int VPC_W2_CYC = (VPC_W2_NS + VPC_CLK_NS - 1) / VPC_CLK_NS;
   localparam int VPC_W3_CYC = (VPC_W3_NS + VPC_CLK_NS - 1) / VPC_CLK_NS;
   localparam logic [3:0] VPC_BITS_PER_BYTE = 4'h8;

   typedef enum logic [2:0] {
      VPC_IDLE,
      VPC_ADDR,
      VPC_SUB,
      VPC_DATA,
      VPC_SKIP
   } vpc_state_e;
endpackage : vpc_pkg

// ==== rtl/vpc_i2c_regs.sv ====
`timescale 1ns/1ps
// Contract
// - answer only write address DCh
// - no subaddress auto increment
// - write transfers only, nothing read back
// - supply drop reloads all defaults
// - contrast in bits 7..1 of 01
// - three gains in bits 7..1, 03..05
// - brightness onto cut-off outputs per coupling
// - bit 7 of 08 picks output clamp
// - bits 4,0 pick pulse source
// - bits 3..2 set clamp pulse width
// - line sync edge select trailing or leading
// - flyback edge from edge and polarity bits
// - bit 0 of 09 inverts flyback
// - bit 1 of 09 forces blanking
// - amp standby overrides amp blanking enable
// - bit 2 of 09 selects coupling
// - cut-off registers set pedestal or output
// - full standby and slew limit in 0D
// - infra depth, common offset, cut-off span
module vpc_i2c_regs
   import vpc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_b,
   input wire logic supply_low,
   input wire logic flyback_in,
   input wire logic line_sync_in,
   output logic [6:0] contrast_level,
   output logic [6:0] chan_one_gain,
   output logic [6:0] chan_two_gain,
   output logic [6:0] chan_three_gain,
   output logic [1:0] luma_offset_span,
   output logic [3:0] overlay_contrast,
   output logic [8:0] cutoff_out_one,
   output logic [8:0] cutoff_out_two,
   output logic [8:0] cutoff_out_three,
   output logic [7:0] pedestal_ch1,
   output logic [7:0] pedestal_ch2,
   output logic [7:0] pedestal_ch3,
   output logic coupling_sel,
   output logic full_sleep,
   output logic [3:0] slew_limit,
   output logic infra_pulse_depth,
   output logic [5:0] common_offset,
   output logic cutoff_span,
   output logic [7:0] enhance_main,
   output logic [7:0] enhance_sharpen,
   output logic input_clamp_pulse,
   output logic output_clamp_pulse,
   output logic flyback_internal,
   output logic video_blank,
   output logic amp_standby,
   output logic amp_blank
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic scl_m_ff, scl_s_ff, scl_d_ff;
   logic sda_m_ff, sda_s_ff, sda_d_ff;
   logic fly_m_ff, fly_s_ff, fly_d_ff;
   logic ls_m_ff, ls_s_ff, ls_d_ff;
   logic sup_m_ff, sup_s_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {scl_m_ff, scl_s_ff, scl_d_ff} <= 3'h7;
         {sda_m_ff, sda_s_ff, sda_d_ff} <= 3'h7;
         {fly_m_ff, fly_s_ff, fly_d_ff} <= 3'h0;
         {ls_m_ff, ls_s_ff, ls_d_ff} <= 3'h0;
         {sup_m_ff, sup_s_ff} <= 2'h0;
      end else begin
         {scl_m_ff, scl_s_ff, scl_d_ff} <= {scl_in, scl_m_ff, scl_s_ff};
         {sda_m_ff, sda_s_ff, sda_d_ff} <= {sda_in, sda_m_ff, sda_s_ff};
         {fly_m_ff, fly_s_ff, fly_d_ff} <= {flyback_in, fly_m_ff, fly_s_ff};
         {ls_m_ff, ls_s_ff, ls_d_ff} <= {line_sync_in, ls_m_ff, ls_s_ff};
         {sup_m_ff, sup_s_ff} <= {supply_low, sup_m_ff};
      end
   end

   logic scl_rise, scl_fall, start_det, stop_det;
   assign scl_rise = scl_s_ff & ~scl_d_ff;
   assign scl_fall = ~scl_s_ff & scl_d_ff;
   // sda edges only count while scl stays high
   assign start_det = scl_s_ff & scl_d_ff & ~sda_s_ff & sda_d_ff;
   assign stop_det = scl_s_ff & scl_d_ff & sda_s_ff & ~sda_d_ff;

   // ----------------------------------------
   // bus slave
   // ----------------------------------------
   vpc_state_e state_ff;
   logic [3:0] cnt_ff;
   logic [7:0] shift_ff;
   logic [7:0] sub_ff;
   logic [7:0] data_ff;
   logic ack_ff;
   logic commit;
   logic sub_ok;

   assign sub_ok = (sub_ff >= 8'(VPC_OFS_CONTRAST)) && (sub_ff <= 8'(VPC_OFS_ENH_SHARP));
   assign commit = scl_fall & ack_ff & (state_ff == VPC_DATA) & sub_ok;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state_ff <= VPC_IDLE;
         cnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         sub_ff <= 8'h00;
         data_ff <= 8'h00;
         ack_ff <= 1'b0;
         sda_oe_b <= 1'b1;
      end else if (start_det) begin
         state_ff <= VPC_ADDR;
         cnt_ff <= 4'h0;
         ack_ff <= 1'b0;
         sda_oe_b <= 1'b1;
      end else if (stop_det) begin
         state_ff <= VPC_IDLE;
         ack_ff <= 1'b0;
         sda_oe_b <= 1'b1;
      end else if (scl_rise && !ack_ff && cnt_ff != VPC_BITS_PER_BYTE) begin
         shift_ff <= {shift_ff[6:0], sda_s_ff};
         cnt_ff <= cnt_ff + 4'h1;
      end else if (scl_fall && ack_ff) begin
         // release after the ack slot, then move on
         ack_ff <= 1'b0;
         sda_oe_b <= 1'b1;
         cnt_ff <= 4'h0;
         case (state_ff)
            VPC_ADDR: state_ff <= VPC_SUB;
            VPC_SUB: state_ff <= VPC_DATA;
            VPC_DATA: state_ff <= VPC_SKIP;
            default: state_ff <= VPC_SKIP;
         endcase
      end else if (scl_fall && cnt_ff == VPC_BITS_PER_BYTE) begin
         case (state_ff)
            VPC_ADDR: begin
               // read address and foreign addresses get no ack
               if (shift_ff == VPC_DEV_WR_ADDR) begin
                  ack_ff <= 1'b1;
                  sda_oe_b <= 1'b0;
               end else begin
                  state_ff <= VPC_SKIP;
               end
            end
            VPC_SUB: begin
               sub_ff <= shift_ff;
               ack_ff <= 1'b1;
               sda_oe_b <= 1'b0;
            end
            VPC_DATA: begin
               data_ff <= shift_ff;
               ack_ff <= 1'b1;
               sda_oe_b <= 1'b0;
            end
            default: state_ff <= state_ff;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sda_out <= 1'b0;
      end else begin
         sda_out <= 1'b0;
      end
   end

   // ----------------------------------------
   // register bank
   // ----------------------------------------
   logic [7:0] regs_ff [VPC_OFS_CONTRAST:VPC_OFS_ENH_SHARP];

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         regs_ff <= VPC_RST_VAL;
      end else if (sup_s_ff) begin
         regs_ff <= VPC_RST_VAL;
      end else if (commit) begin
         // reserved bits stored as written; software keeps them zero
         regs_ff[sub_ff] <= data_ff;
      end
   end

   logic [7:0] clamp_cfg, amp_cfg, infra_cfg, sleep_cfg;
   assign clamp_cfg = regs_ff[VPC_OFS_CLAMP_CFG];
   assign amp_cfg = regs_ff[VPC_OFS_AMP_CFG];
   assign infra_cfg = regs_ff[VPC_OFS_INFRA_CFG];
   assign sleep_cfg = regs_ff[VPC_OFS_SLEEP_CFG];

   assign contrast_level = regs_ff[VPC_OFS_CONTRAST][7:1];
   assign chan_one_gain = regs_ff[VPC_OFS_GAIN_ONE][7:1];
   assign chan_two_gain = regs_ff[VPC_OFS_GAIN_TWO][7:1];
   assign chan_three_gain = regs_ff[VPC_OFS_GAIN_THREE][7:1];
   assign luma_offset_span = regs_ff[VPC_OFS_LUMA_SPAN][1:0];
   assign overlay_contrast = regs_ff[VPC_OFS_OVERLAY][3:0];
   assign coupling_sel = amp_cfg[VPC_B_COUPLE];
   assign full_sleep = sleep_cfg[VPC_B_FULL_SLEEP];
   assign slew_limit = sleep_cfg[3:0];
   assign infra_pulse_depth = infra_cfg[VPC_B_INFRA_DEPTH];
   assign common_offset = infra_cfg[6:1];
   assign cutoff_span = infra_cfg[VPC_B_CUTOFF_SPAN];
   assign enhance_main = regs_ff[VPC_OFS_ENH_MAIN];
   assign enhance_sharpen = regs_ff[VPC_OFS_ENH_SHARP];

   // ----------------------------------------
   // cut-off and brightness codes
   // ----------------------------------------
   logic [8:0] bri9;
   assign bri9 = {1'b0, regs_ff[VPC_OFS_LUMA_OFFSET]};

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cutoff_out_one <= 9'h000;
         cutoff_out_two <= 9'h000;
         cutoff_out_three <= 9'h000;
         pedestal_ch1 <= 8'h00;
         pedestal_ch2 <= 8'h00;
         pedestal_ch3 <= 8'h00;
      end else if (coupling_sel) begin
         // ac coupled: brightness rides on each cut-off level
         cutoff_out_one <= bri9 + {1'b0, regs_ff[VPC_OFS_CUTOFF1]};
         cutoff_out_two <= bri9 + {1'b0, regs_ff[VPC_OFS_CUTOFF2]};
         cutoff_out_three <= bri9 + {1'b0, regs_ff[VPC_OFS_CUTOFF3]};
         pedestal_ch1 <= 8'h00;
         pedestal_ch2 <= 8'h00;
         pedestal_ch3 <= 8'h00;
      end else begin
         cutoff_out_one <= 9'h000;
         cutoff_out_two <= 9'h000;
         cutoff_out_three <= bri9;
         pedestal_ch1 <= regs_ff[VPC_OFS_CUTOFF1];
         pedestal_ch2 <= regs_ff[VPC_OFS_CUTOFF2];
         pedestal_ch3 <= regs_ff[VPC_OFS_CUTOFF3];
      end
   end

   // ----------------------------------------
   // clamp pulse generation
   // ----------------------------------------
   logic fly_int, fly_int_d, ls_rise, ls_fall, fly_rise, fly_fall;
   logic in_trig, out_trig;
   logic [7:0] in_cnt_ff, out_cnt_ff, width_cyc;

   assign fly_int = fly_s_ff ^ amp_cfg[VPC_B_FLY_INV];
   assign fly_int_d = fly_d_ff ^ amp_cfg[VPC_B_FLY_INV];
   assign ls_rise = ls_s_ff & ~ls_d_ff;
   assign ls_fall = ~ls_s_ff & ls_d_ff;
   assign fly_rise = fly_s_ff & ~fly_d_ff;
   assign fly_fall = ~fly_s_ff & fly_d_ff;

   always_comb begin
      case (clamp_cfg[3:2])
         2'h0: width_cyc = 8'(VPC_W0_CYC);
         2'h1: width_cyc = 8'(VPC_W1_CYC);
         2'h2: width_cyc = 8'(VPC_W2_CYC);
         default: width_cyc = 8'(VPC_W3_CYC);
      endcase
      if (clamp_cfg[VPC_B_SRC_LO]) begin
         // flyback pin edge: rising when edge and polarity bits agree
         in_trig = (clamp_cfg[VPC_B_EDGE] == amp_cfg[VPC_B_FLY_INV]) ? fly_rise : fly_fall;
      end else begin
         in_trig = clamp_cfg[VPC_B_EDGE] ? ls_rise : ls_fall;
      end
   end

   // output clamp follows the leading edge of the internal flyback
   assign out_trig = fly_int & ~fly_int_d;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         in_cnt_ff <= 8'h00;
      end else if (in_trig) begin
         in_cnt_ff <= width_cyc;
      end else if (in_cnt_ff != 8'h00) begin
         in_cnt_ff <= in_cnt_ff - 8'h01;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         out_cnt_ff <= 8'h00;
      end else if (out_trig) begin
         out_cnt_ff <= width_cyc;
      end else if (out_cnt_ff != 8'h00) begin
         out_cnt_ff <= out_cnt_ff - 8'h01;
      end
   end

   logic nxt_input_clamp_pulse;
   // source 1x hands the line sync straight through
   assign nxt_input_clamp_pulse = clamp_cfg[VPC_B_SRC_HI] ? ls_s_ff : (in_trig | (in_cnt_ff != 8'h00));

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         input_clamp_pulse <= 1'b0;
         output_clamp_pulse <= 1'b0;
      end else begin
         input_clamp_pulse <= nxt_input_clamp_pulse;
         output_clamp_pulse <= clamp_cfg[VPC_B_OUT_CLAMP_SRC] ? nxt_input_clamp_pulse
                               : (out_trig | (out_cnt_ff != 8'h00));
      end
   end

   // ----------------------------------------
   // blanking and amplifier control
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         flyback_internal <= 1'b0;
         video_blank <= 1'b0;
         amp_standby <= 1'b0;
         amp_blank <= 1'b0;
      end else begin
         flyback_internal <= fly_int;
         // soft blanking is only valid with the first test bit set; here bit 1 of 09 forces video_blank whatever bit 6 of 08 holds
         video_blank <= amp_cfg[VPC_B_SOFT_BLANK] | fly_int;
         amp_standby <= amp_cfg[VPC_B_AMP_SLEEP] | full_sleep;
         amp_blank <= ~amp_cfg[VPC_B_AMP_SLEEP] & ~full_sleep & amp_cfg[VPC_B_AMP_BLANK] & fly_int;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   logic byte_end;
   assign byte_end = scl_fall && !ack_ff && !start_det && !stop_det && cnt_ff == VPC_BITS_PER_BYTE;

   dev_addr_ack_a: assert property (byte_end && state_ff == VPC_ADDR && shift_ff == VPC_DEV_WR_ADDR
      |=> !sda_oe_b && !sda_out) else $error("own address not acked");
   foreign_addr_a: assert property (byte_end && state_ff == VPC_ADDR && shift_ff != VPC_DEV_WR_ADDR
      |=> sda_oe_b && state_ff == VPC_SKIP) else $error("foreign address acked");
   no_autoinc_a: assert property (scl_fall && ack_ff && !start_det && !stop_det && state_ff == VPC_DATA
      |=> state_ff == VPC_SKIP ##1 (sda_oe_b throughout (state_ff == VPC_SKIP)[*2]))
      else $error("second data byte accepted");
   skip_silent_a: assert property (state_ff == VPC_SKIP |-> sda_oe_b) else $error("driving sda while skipping");
   supply_default_a: assert property (sup_s_ff |=> regs_ff[VPC_OFS_INFRA_CFG] == VPC_RST_VAL[VPC_OFS_INFRA_CFG]
      && regs_ff[VPC_OFS_CONTRAST] == VPC_RST_VAL[VPC_OFS_CONTRAST]) else $error("supply drop kept value");
   commit_write_a: assert property (commit && !sup_s_ff && sub_ff == 8'(VPC_OFS_AMP_CFG)
      |=> amp_cfg == $past(data_ff)) else $error("data byte not committed");
   unmapped_write_a: assert property (scl_fall && ack_ff && state_ff == VPC_DATA && !sub_ok && !sup_s_ff
      |=> $stable(regs_ff[VPC_OFS_CONTRAST]) && $stable(regs_ff[VPC_OFS_ENH_SHARP]))
      else $error("unmapped write changed a register");
   dc_bright_a: assert property (!coupling_sel && $stable(bri9) |=> cutoff_out_three == $past(bri9)
      && cutoff_out_one == 9'h000) else $error("dc brightness routing wrong");
   soft_blank_a: assert property (amp_cfg[VPC_B_SOFT_BLANK] ##1 amp_cfg[VPC_B_SOFT_BLANK] |-> video_blank)
      else $error("soft blanking not forced");
   sleep_blank_a: assert property (amp_cfg[VPC_B_AMP_SLEEP] |=> !amp_blank && amp_standby)
      else $error("blanking active in standby");
   clamp_width_a: assert property (in_trig && !clamp_cfg[VPC_B_SRC_HI] && clamp_cfg[3:2] == 2'h0
      && !start_det |=> in_cnt_ff == 8'(VPC_W0_CYC)) else $error("clamp width wrong");

   addr_ack_c: cover property (byte_end && state_ff == VPC_ADDR && shift_ff == VPC_DEV_WR_ADDR);
   commit_c: cover property (commit);
   in_clamp_c: cover property (in_trig ##1 input_clamp_pulse [*8]);
   unmapped_c: cover property (scl_fall && ack_ff && state_ff == VPC_DATA && !sub_ok);

endmodule : vpc_i2c_regs

// ==== test/vpc_i2c_master.sv ====
`timescale 1ns/1ps
module vpc_i2c_master (
   output logic scl,
   output logic sda_pull,
   input wire logic sda_wire
);
   initial begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end

   // ----------------------------------------
   // bit slots of 125 ns, byte slots of 1125 ns
   // ----------------------------------------
   // data moves mid low phase, so setup and hold both get a quarter slot
   task automatic put_bit(input logic b);
      #31 sda_pull = ~b;
      #31 scl = 1'b1;
      #63 scl = 1'b0;
   endtask : put_bit

   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         put_bit(b[i]);
      end
      #31 sda_pull = 1'b0;
      #31 scl = 1'b1;
      #31 ack = ~sda_wire;
      #32 scl = 1'b0;
   endtask : send_byte

   // ----------------------------------------
   // one register per transfer
   // ----------------------------------------
   // extra byte only when a scenario wants to break the one-byte order
   task automatic xfer(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] dat,
                       input logic extra, output logic [3:0] acks);
      acks = 4'h0;
      sda_pull = 1'b1;
      #63 scl = 1'b0;
      send_byte(dev, acks[3]);
      send_byte(sub, acks[2]);
      send_byte(dat, acks[1]);
      if (extra) begin
         send_byte(~dat, acks[0]);
      end
      #31 sda_pull = 1'b1;
      #31 scl = 1'b1;
      #63 sda_pull = 1'b0;
      #1300;
   endtask : xfer
endmodule : vpc_i2c_master

// ==== test/test_vpc_i2c_regs.sv ====
`timescale 1ns/1ps
module test_vpc_i2c_regs
   import vpc_pkg::*;
;
   logic clk, rst_b, supply_low, flyback_in, line_sync_in, scl_in, sda_in, sda_pull, sda_out, sda_oe_b;
   logic [6:0] contrast_level, chan_one_gain, chan_two_gain, chan_three_gain;
   logic [1:0] luma_offset_span;
   logic [3:0] overlay_contrast, slew_limit;
   logic [8:0] cutoff_out_one, cutoff_out_two, cutoff_out_three;
   logic [7:0] pedestal_ch1, pedestal_ch2, pedestal_ch3, enhance_main, enhance_sharpen;
   logic coupling_sel, full_sleep, infra_pulse_depth, cutoff_span, input_clamp_pulse, output_clamp_pulse;
   logic flyback_internal, video_blank, amp_standby, amp_blank;
   logic [5:0] common_offset;
   logic [7:0] shadow [1:16];
   int failures = 0;
   int checks_done = 0;

   // wire-and of both pullers with the bus pull-up
   assign sda_in = !(sda_pull || (!sda_oe_b && !sda_out));

   vpc_i2c_regs u_vpc_i2c_regs (.*);
   vpc_i2c_master u_vpc_i2c_master (.scl(scl_in), .sda_pull(sda_pull), .sda_wire(sda_in));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test

   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : settle

   task automatic xfer(input logic [7:0] dev, input logic [7:0] sub, input logic [7:0] dat,
                       input logic extra, input logic [3:0] exp_ack);
      logic [3:0] acks;
      u_vpc_i2c_master.xfer(dev, sub, dat, extra, acks);
      chk("ack", exp_ack, acks);
      settle(5);
   endtask : xfer

   task automatic wr(input logic [7:0] sub, input logic [7:0] dat);
      xfer(VPC_DEV_WR_ADDR, sub, dat, 1'b0, 4'hE);
      shadow[sub] = dat;
   endtask : wr

   task automatic check_all();
      logic ac;
      ac = shadow[9][2];
      chk("contrast", shadow[1][7:1], contrast_level);
      chk("gain1", shadow[3][7:1], chan_one_gain);
      chk("gain2", shadow[4][7:1], chan_two_gain);
      chk("gain3", shadow[5][7:1], chan_three_gain);
      chk("span", shadow[6][1:0], luma_offset_span);
      chk("overlay", shadow[7][3:0], overlay_contrast);
      chk("couple", ac, coupling_sel);
      chk("co1", ac ? shadow[2] + shadow[10] : 9'h000, cutoff_out_one);
      chk("co2", ac ? shadow[2] + shadow[11] : 9'h000, cutoff_out_two);
      chk("co3", ac ? shadow[2] + shadow[12] : shadow[2], cutoff_out_three);
      chk("ped1", ac ? 8'h00 : shadow[10], pedestal_ch1);
      chk("ped2", ac ? 8'h00 : shadow[11], pedestal_ch2);
      chk("ped3", ac ? 8'h00 : shadow[12], pedestal_ch3);
      chk("sleep", shadow[13][7], full_sleep);
      chk("slew", shadow[13][3:0], slew_limit);
      chk("standby", shadow[9][7] | shadow[13][7], amp_standby);
      chk("depth", shadow[14][7], infra_pulse_depth);
      chk("offset", shadow[14][6:1], common_offset);
      chk("cspan", shadow[14][0], cutoff_span);
      chk("enh", shadow[15], enhance_main);
      chk("sharp", shadow[16], enhance_sharpen);
   endtask : check_all

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_all_regs();
      // reserved bits zero, gain and contrast fields clear of 00 and 7Fh
      logic [7:0] vals [1:16] = '{8'h5A, 8'h37, 8'h22, 8'h44, 8'h66, 8'h02, 8'h05, 8'h04,
                                  8'h14, 8'h11, 8'hF0, 8'hEE, 8'h8B, 8'h4A, 8'h89, 8'hAA};
      for (int s = 1; s <= 16; s++) begin
         wr(8'(s), vals[s]);
      end
      check_all();
      wr(8'h09, 8'h10);
      check_all();
   endtask : t_all_regs

   task automatic t_refused();
      xfer(8'hDE, 8'h01, 8'h3C, 1'b0, 4'h0);
      xfer(8'hDD, 8'h01, 8'h3C, 1'b0, 4'h0);
      xfer(VPC_DEV_WR_ADDR, 8'h01, 8'h3C, 1'b1, 4'hE);
      shadow[1] = 8'h3C;
      xfer(VPC_DEV_WR_ADDR, 8'h00, 8'h3C, 1'b0, 4'hE);
      xfer(VPC_DEV_WR_ADDR, 8'h11, 8'h3C, 1'b0, 4'hE);
      check_all();
   endtask : t_refused

   task automatic t_supply();
      @(posedge clk);
      supply_low <= 1'b1;
      settle(10);
      supply_low <= 1'b0;
      settle(5);
      for (int s = 1; s <= 16; s++) begin
         shadow[s] = VPC_RST_VAL[s];
      end
      check_all();
   endtask : t_supply

   task automatic fly(input logic v, input logic [3:0] exp);
      @(posedge clk);
      flyback_in <= v;
      settle(8);
      chk("blank", exp, {flyback_internal, video_blank, amp_blank, amp_standby});
   endtask : fly

   task automatic t_blank();
      wr(8'h08, 8'h44);
      wr(8'h09, 8'h13);
      fly(1'b1, 4'h4);
      wr(8'h09, 8'h51);
      fly(1'b0, 4'hE);
      fly(1'b1, 4'h0);
      wr(8'h09, 8'hD1);
      fly(1'b0, 4'hD);
      wr(8'h09, 8'h10);
      fly(1'b0, 4'h0);
   endtask : t_blank

   // pin high for 150 cycles then low for 150; input clamp highs counted per phase, output clamp highs over both
   task automatic pulse(input logic on_fly, input int ea, input int eb, input int ec);
      int a, b, c;
      a = 0;
      b = 0;
      c = 0;
      for (int i = 0; i < 300; i++) begin
         @(posedge clk);
         if (on_fly) flyback_in <= (i < 150);
         else line_sync_in <= (i < 150);
         #1;
         if (input_clamp_pulse === 1'b1 && i < 150) a++;
         if (input_clamp_pulse === 1'b1 && i >= 150) b++;
         if (output_clamp_pulse === 1'b1) c++;
      end
      chk("in clamp lead", ea, a);
      chk("in clamp trail", eb, b);
      chk("out clamp", ec, c);
   endtask : pulse

   task automatic t_clamp();
      int w [4] = '{VPC_W0_CYC + 1, VPC_W1_CYC + 1, VPC_W2_CYC + 1, VPC_W3_CYC + 1};
      for (int i = 0; i < 4; i++) begin
         wr(8'h08, 8'(i << 2));
         pulse(1'b0, 0, w[i], 0);
      end
      wr(8'h08, 8'h86);
      pulse(1'b0, w[1], 0, w[1]);
      wr(8'h08, 8'h05);
      pulse(1'b1, w[1], 0, w[1]);
      wr(8'h08, 8'h07);
      pulse(1'b1, 0, w[1], w[1]);
      wr(8'h08, 8'h10);
      pulse(1'b0, 147, 3, 0);
   endtask : t_clamp

   initial begin
      rst_b = 1'b0;
      supply_low = 1'b0;
      flyback_in = 1'b0;
      line_sync_in = 1'b0;
      for (int s = 1; s <= 16; s++) begin
         shadow[s] = VPC_RST_VAL[s];
      end
      repeat (20) @(posedge clk);
      rst_b <= 1'b1;
      settle(5);
      check_all();
      t_all_regs();
      t_refused();
      t_supply();
      t_blank();
      t_clamp();
      stop_test();
   end

   initial begin
      #400000;
      failures++;
      stop_test();
   end
endmodule : test_vpc_i2c_regs
